// ---- roc_off_timer.sv ----
`timescale 1ns/10ps
module roc_off_timer #(
    parameter int W = 16
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic start,
    input wire logic abort,
    input wire logic [W-1:0] count,
    output logic done
);
    if (W < 1)
    begin : g_w_chk
        $error("W too small");
    end
    logic [W-1:0] cnt_q, cnt_d;
    logic run_q, run_d, done_q, done_d;
    always_comb
    begin
        cnt_d = cnt_q;
        run_d = run_q;
        done_d = 1'b0;
        if (abort)
        begin
            run_d = 1'b0;
        end
        else if (start)
        begin
            cnt_d = count;
            run_d = 1'b1;
        end
        else if (run_q)
        begin
            if (cnt_q <= {{(W-1){1'b0}}, 1'b1})
            begin
                run_d = 1'b0;
                done_d = 1'b1;
            end
            else
                cnt_d = cnt_q - {{(W-1){1'b0}}, 1'b1};
        end
    end
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            cnt_q <= '0;
            run_q <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            run_q <= run_d;
            done_q <= done_d;
        end
    end
    assign done = done_q;
endmodule // roc_off_timer

// ---- roc_peer_model.sv ----
`timescale 1ns/10ps
module roc_peer_model (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic send,
    input wire logic [1:0] send_kind,
    input wire logic [4:0] send_id,
    output logic bus_ev_valid,
    output logic [1:0] bus_ev_kind,
    output logic [4:0] bus_ev_id
);
    always_ff @(posedge mclk)
    begin
        bus_ev_valid <= send & ~sys_rst;
        // Idle lines flip so a stale event never matches
        bus_ev_kind <= send ? send_kind : ~bus_ev_kind;
        bus_ev_id <= send ? send_id : ~bus_ev_id;
    end
endmodule // roc_peer_model

// ---- roc_pkg.sv ----
package roc_pkg;
    localparam logic [7:0] ORDER_OFS = 8'he0;
    localparam logic [7:0] FOLLOW_OFS = 8'he1;
    localparam logic [15:0] ORDER_RST = 16'h0000;
    localparam logic [7:0] FOLLOW_RST = 8'h00;
    localparam logic [15:0] ORDER_MASK = 16'h9f9f;
    localparam logic [7:0] FOLLOW_MASK = 8'h86;
    localparam int PRE_EN_BIT = 15;
    localparam int PRE_ID_LSB = 8;
    localparam int SUC_EN_BIT = 7;
    localparam int SUC_ID_LSB = 0;
    localparam int ID_W = 5;
    localparam int FOL_EN_BIT = 7;
    localparam int FOL_HALF_BIT = 2;
    localparam int FOL_LIM_BIT = 1;
    localparam int OFF_DELAY_NS = 1000;
    localparam int CLK_NS = 100;
    localparam int OFF_DELAY_CYC = (OFF_DELAY_NS + CLK_NS - 1) / CLK_NS;
    typedef enum logic [1:0] {EV_NONE, EV_PG, EV_DOWN} roc_ev_t;
    typedef enum logic [1:0] {ST_OFF, ST_WAIT, ST_ON, ST_DELAY} roc_st_t;
endpackage

// ---- roc_rail_order.sv ----
`timescale 1ns/10ps
module roc_rail_order #(
    parameter int DLY_W = 16,
    parameter logic [DLY_W-1:0] OFF_CYCLES = DLY_W'(roc_pkg::OFF_DELAY_CYC)
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire logic [15:0] cfg_wdata,
    output logic [15:0] cfg_rdata,
    input wire logic own_enable,
    input wire logic fault,
    input wire logic in_group,
    input wire logic [4:0] own_id,
    input wire logic bus_ev_valid,
    input wire logic [1:0] bus_ev_kind,
    input wire logic [4:0] bus_ev_id,
    input wire logic retry_req,
    input wire logic margin_hi_req,
    input wire logic margin_lo_req,
    output logic out_on,
    output logic tx_valid,
    output logic [1:0] tx_kind,
    output logic [4:0] tx_id,
    output logic follow_en,
    output logic follow_half,
    output logic follow_ref_limit,
    output logic follow_start,
    output logic margin_hi,
    output logic margin_lo,
    output logic retry_go
);
    // Timer needs a count above one to be useful
    if (DLY_W < 2)
    begin : g_dly_chk
        $error("DLY_W too small");
    end
    // A zero delay would quietly wait one cycle
    if (OFF_CYCLES == '0)
    begin : g_off_chk
        $error("OFF_CYCLES must be nonzero");
    end
    // Id fields must stay inside their own byte
    if (roc_pkg::PRE_ID_LSB + roc_pkg::ID_W > 16 ||
        roc_pkg::SUC_ID_LSB + roc_pkg::ID_W > 8)
    begin : g_id_chk
        $error("Rail id field outside its byte");
    end
    // Configuration words are stored already masked
    logic [15:0] order_q, order_d;
    logic [7:0] follow_q, follow_d;
    logic [15:0] rdata_q, rdata_d;
    roc_pkg::roc_st_t st_q, st_d;
    logic on_q, on_d, txv_q, txv_d, fs_q, fs_d;
    logic [1:0] txk_q, txk_d;
    logic mh_q, mh_d, ml_q, ml_d, rg_q, rg_d, fault_off_q, fault_off_d;
    logic tmr_start, tmr_abort, tmr_done;
    logic pre_en, suc_en, pre_hit, suc_hit, trk;

    // A bus event counts only with matching kind and rail id
    function automatic logic ev_match(input logic [1:0] kind,
        input roc_pkg::roc_ev_t want, input logic [4:0] id,
        input logic [4:0] cfg_id);
        ev_match = bus_ev_valid && kind == 2'(want) && id == cfg_id;
    endfunction

    // One decoder keeps the read and write maps in step
    function automatic logic is_order(input logic [7:0] addr);
        is_order = addr == roc_pkg::ORDER_OFS;
    endfunction

    function automatic logic is_follow(input logic [7:0] addr);
        is_follow = addr == roc_pkg::FOLLOW_OFS;
    endfunction

    // Enables and ids decoded straight from the stored word

    assign pre_en = order_q[roc_pkg::PRE_EN_BIT];
    assign suc_en = order_q[roc_pkg::SUC_EN_BIT];
    assign pre_hit = ev_match(bus_ev_kind, roc_pkg::EV_PG, bus_ev_id,
        order_q[roc_pkg::PRE_ID_LSB +: roc_pkg::ID_W]);
    assign suc_hit = ev_match(bus_ev_kind, roc_pkg::EV_DOWN, bus_ev_id,
        order_q[roc_pkg::SUC_ID_LSB +: roc_pkg::ID_W]);
    assign trk = follow_q[roc_pkg::FOL_EN_BIT];

    always_comb
    begin
        order_d = order_q;
        follow_d = follow_q;
        rdata_d = rdata_q;
        // Unmapped reads give zero, unmapped writes are dropped
        if (cfg_wr)
        begin
            if (is_order(cfg_addr))
                order_d = cfg_wdata & roc_pkg::ORDER_MASK;
            else if (is_follow(cfg_addr))
                follow_d = cfg_wdata[7:0] & roc_pkg::FOLLOW_MASK;
        end
        if (cfg_rd)
        begin
            if (is_order(cfg_addr))
                rdata_d = order_q;
            else if (is_follow(cfg_addr))
                rdata_d = {8'h00, follow_q};
            else
                rdata_d = 16'h0000;
        end
    end

    // Fault path never touches the bus transmitter
    always_comb
    begin
        st_d = st_q;
        on_d = on_q;
        txv_d = 1'b0;
        txk_d = txk_q;
        fs_d = 1'b0;
        tmr_start = 1'b0;
        tmr_abort = 1'b0;
        fault_off_d = fault_off_q;
        rg_d = 1'b0;
        if (fault)
        begin
            // Local shutdown only, neighbours are not told
            st_d = roc_pkg::ST_OFF;
            on_d = 1'b0;
            tmr_abort = 1'b1;
            fault_off_d = 1'b1;
        end
        else
        begin
            // Grouped rails hold off until re-enabled
            if (fault_off_q && retry_req)
            begin
                if (!(pre_en || suc_en || in_group))
                begin
                    rg_d = 1'b1;
                    fault_off_d = 1'b0;
                end
            end
            if (fault_off_q && !own_enable)
                fault_off_d = 1'b0;
            // Power-good only counts while waiting to start
            case (st_q)
                roc_pkg::ST_OFF:
                begin
                    if (own_enable && !fault_off_q)
                        st_d = roc_pkg::ST_WAIT;
                end
                roc_pkg::ST_WAIT:
                begin
                    if (!own_enable)
                        st_d = roc_pkg::ST_OFF;
                    else if (!pre_en || pre_hit)
                    begin
                        st_d = roc_pkg::ST_ON;
                        on_d = 1'b1;
                        fs_d = trk;
                        txv_d = 1'b1;
                        txk_d = 2'(roc_pkg::EV_PG);
                    end
                end
                roc_pkg::ST_ON:
                begin
                    if (!own_enable || (suc_en && suc_hit))
                    begin
                        st_d = roc_pkg::ST_DELAY;
                        tmr_start = 1'b1;
                    end
                end
                roc_pkg::ST_DELAY:
                begin
                    // Timer carries the fixed OFF_CYCLES turn-off delay
                    if (tmr_done)
                    begin
                        st_d = roc_pkg::ST_OFF;
                        on_d = 1'b0;
                        txv_d = 1'b1;
                        txk_d = 2'(roc_pkg::EV_DOWN);
                    end
                end
                default:
                    st_d = roc_pkg::ST_OFF;
            endcase
        end
        // Margin requests are held back while tracking
        mh_d = margin_hi_req && !trk;
        ml_d = margin_lo_req && !trk;
    end

    // Delay counter kept apart so its width can grow alone
    roc_off_timer #(.W(DLY_W)) u_off_timer (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .start(tmr_start),
        .abort(tmr_abort),
        .count(OFF_CYCLES),
        .done(tmr_done)
    );

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            order_q <= roc_pkg::ORDER_RST;
            follow_q <= roc_pkg::FOLLOW_RST;
            rdata_q <= 16'h0000;
        end
        else
        begin
            order_q <= order_d;
            follow_q <= follow_d;
            rdata_q <= rdata_d;
        end
    end

    // Sequencer state kept apart from the register file
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            st_q <= roc_pkg::ST_OFF;
            on_q <= 1'b0;
            txv_q <= 1'b0;
            txk_q <= 2'h0;
            fs_q <= 1'b0;
            mh_q <= 1'b0;
            ml_q <= 1'b0;
            rg_q <= 1'b0;
            fault_off_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            on_q <= on_d;
            txv_q <= txv_d;
            txk_q <= txk_d;
            fs_q <= fs_d;
            mh_q <= mh_d;
            ml_q <= ml_d;
            rg_q <= rg_d;
            fault_off_q <= fault_off_d;
        end
    end

    // Tracking controls change in the cycle the byte is written
    logic [4:0] id_q, id_d;
    logic en_q, en_d, half_q, half_d, lim_q, lim_d;
    always_comb
    begin
        id_d = own_id;
        en_d = follow_d[roc_pkg::FOL_EN_BIT];
        half_d = follow_d[roc_pkg::FOL_HALF_BIT];
        lim_d = follow_d[roc_pkg::FOL_LIM_BIT];
    end
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            id_q <= 5'h00;
            en_q <= 1'b0;
            half_q <= 1'b0;
            lim_q <= 1'b0;
        end
        else
        begin
            id_q <= id_d;
            en_q <= en_d;
            half_q <= half_d;
            lim_q <= lim_d;
        end
    end

    // Every output is a register, nothing in between
    assign cfg_rdata = rdata_q;
    assign out_on = on_q;
    assign tx_valid = txv_q;
    assign tx_kind = txk_q;
    assign tx_id = id_q;
    assign follow_en = en_q;
    assign follow_half = half_q;
    assign follow_ref_limit = lim_q;
    assign follow_start = fs_q;
    assign margin_hi = mh_q;
    assign margin_lo = ml_q;
    assign retry_go = rg_q;
endmodule // roc_rail_order

// ---- roc_rail_order_properties.sv ----
`timescale 1ns/10ps
module roc_rail_order_properties (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire logic [15:0] cfg_rdata,
    input wire logic own_enable,
    input wire logic fault,
    input wire logic in_group,
    input wire logic retry_req,
    input wire logic out_on,
    input wire logic tx_valid,
    input wire logic [1:0] tx_kind,
    input wire logic follow_en,
    input wire logic follow_half,
    input wire logic follow_ref_limit,
    input wire logic follow_start,
    input wire logic margin_hi,
    input wire logic margin_lo,
    input wire logic retry_go
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    a_rise_cause: assert property (
        $rose(out_on) |-> $past(own_enable) && tx_valid && tx_kind == 2'h1)
        else $error("on without cause");
    a_off_event: assert property (
        $fell(out_on) && !$past(fault) |-> tx_valid && tx_kind == 2'h2)
        else $error("off without event");
    a_fault_quiet: assert property (fault |=> !out_on && !tx_valid)
        else $error("fault sent event");
    a_retry_group: assert property (
        retry_go |-> $past(retry_req) && !$past(in_group))
        else $error("grouped retry");
    a_margin_gate: assert property (
        follow_en && $past(follow_en) |-> !margin_hi && !margin_lo)
        else $error("margin while tracking");
    a_follow_read: assert property (
        $past(cfg_rd && cfg_addr == 8'he1) |-> cfg_rdata ==
        {8'h00, follow_en, 4'h0, follow_half, follow_ref_limit, 1'b0})
        else $error("tracking byte mismatch");
    a_order_mask: assert property (
        $past(cfg_rd && cfg_addr == 8'he0) |-> (cfg_rdata & 16'h6060) == 0)
        else $error("unused order bits set");
    a_start_track: assert property (
        follow_start |-> out_on && follow_en)
        else $error("start without tracking");
endmodule // roc_rail_order_properties
bind roc_rail_order roc_rail_order_properties u_props (.mclk(mclk),
    .sys_rst(sys_rst), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
    .cfg_rdata(cfg_rdata), .own_enable(own_enable), .fault(fault),
    .in_group(in_group), .retry_req(retry_req), .out_on(out_on),
    .tx_valid(tx_valid), .tx_kind(tx_kind), .follow_en(follow_en),
    .follow_half(follow_half), .follow_ref_limit(follow_ref_limit),
    .follow_start(follow_start), .margin_hi(margin_hi),
    .margin_lo(margin_lo), .retry_go(retry_go));

// ---- testbench.sv ----
`timescale 1ns/10ps
module testbench;
    logic mclk = 1'b0, sys_rst = 1'b1, cfg_wr = 1'b0, cfg_rd = 1'b0;
    logic own_enable = 1'b0, fault = 1'b0, in_group = 1'b0, send = 1'b0;
    logic retry_req = 1'b0, m_req = 1'b0, rd_prev = 1'b0;
    logic [7:0] cfg_addr = 8'h00;
    logic [15:0] cfg_wdata = 16'h0000, seed = 16'h2f8f, v, cfg_rdata;
    logic [1:0] send_kind = 2'h0, ev_kind, tx_kind;
    logic [4:0] send_id = 5'h00, ev_id, tx_id;
    logic ev_valid, out_on, tx_valid, f_en, f_half, f_lim, f_start;
    logic m_hi, m_lo, retry_go;
    logic [15:0] exp_q[$];
    logic [15:0] tx_q[$];
    logic [15:0] tx_exp;
    int fails = 0;
    int n_tests = 0;
    roc_rail_order u_roc_rail_order (.mclk(mclk), .sys_rst(sys_rst),
        .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
        .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .fault(fault),
        .own_enable(own_enable), .in_group(in_group), .own_id(5'h01),
        .bus_ev_valid(ev_valid), .bus_ev_kind(ev_kind), .bus_ev_id(ev_id),
        .retry_req(retry_req), .margin_hi_req(m_req), .margin_lo_req(m_req),
        .out_on(out_on), .tx_valid(tx_valid), .tx_kind(tx_kind),
        .tx_id(tx_id), .follow_en(f_en), .follow_half(f_half),
        .follow_ref_limit(f_lim), .follow_start(f_start), .margin_hi(m_hi),
        .margin_lo(m_lo), .retry_go(retry_go));
    roc_peer_model u_roc_peer_model (.mclk(mclk), .sys_rst(sys_rst),
        .send(send), .send_kind(send_kind), .send_id(send_id),
        .bus_ev_valid(ev_valid), .bus_ev_kind(ev_kind), .bus_ev_id(ev_id));
    initial forever #50 mclk = ~mclk;
    function automatic logic [15:0] nx();
        seed ^= seed << 7;
        seed ^= seed >> 9;
        seed ^= seed << 8;
        return seed;
    endfunction
    task automatic chk(input string n, input logic [15:0] e, g);
        n_tests++;
        if (g !== e)
        begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] a, logic [15:0] d);
        @(posedge mclk);
        cfg_wr <= w;
        cfg_rd <= ~w;
        cfg_addr <= a;
        cfg_wdata <= d;
        if (!w)
            exp_q.push_back(d);
        @(posedge mclk);
        cfg_wr <= 1'b0;
        cfg_rd <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic ev(input logic [1:0] k, input logic [4:0] id);
        @(posedge mclk);
        send <= 1'b1;
        send_kind <= k;
        send_id <= id;
        @(posedge mclk);
        send <= 1'b0;
        repeat (4) @(negedge mclk);
    endtask
    task automatic wait_on(input logic e);
        for (int i = 0; i < 40 && out_on !== e; i++)
            @(negedge mclk);
        chk("out_on", 16'(e), 16'(out_on));
    endtask
    task automatic complete_run();
        $display("Comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Read data lands one cycle after the strobe
    always @(negedge mclk)
    begin
        if (rd_prev)
            chk("cfg_rdata", exp_q.pop_front(), cfg_rdata);
        rd_prev = cfg_rd;
    end
    // Every sent event must have been announced by the stimulus
    always @(negedge mclk)
    begin
        if (tx_valid === 1'b1)
        begin
            tx_exp = tx_q.size() > 0 ? tx_q.pop_front() : 16'hffff;
            chk("tx_event", tx_exp, {9'h0, tx_kind, tx_id});
        end
    end
    initial
    begin
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        acc(0, 8'he0, 16'h0000);
        acc(0, 8'he1, 16'h0000);
        for (int i = 0; i < 4; i++)
        begin
            v = nx();
            acc(1, 8'he0, v);
            acc(0, 8'he0, v & 16'h9f9f);
            acc(1, 8'he1, v);
            acc(0, 8'he1, v & 16'h0086);
            acc(1, 8'he5, v);
            acc(0, 8'he5, 16'h0000);
        end
        $display("registers done");
        acc(1, 8'he0, 16'h0000);
        acc(1, 8'he1, 16'h0086);
        tx_q.push_back(16'h0021);
        m_req <= 1'b1;
        own_enable <= 1'b1;
        wait_on(1'b1);
        chk("follow_start", 16'h0001, 16'(f_start));
        chk("follow", 16'h0007, {13'h0, f_en, f_half, f_lim});
        chk("margin", 16'h0000, {14'h0, m_hi, m_lo});
        tx_q.push_back(16'h0041);
        @(posedge mclk);
        own_enable <= 1'b0;
        wait_on(1'b0);
        acc(1, 8'he1, 16'h0000);
        @(negedge mclk);
        chk("margin", 16'h0003, {14'h0, m_hi, m_lo});
        @(posedge mclk);
        m_req <= 1'b0;
        $display("tracking done");
        acc(1, 8'he0, 16'h8300);
        own_enable <= 1'b1;
        ev(roc_pkg::EV_PG, 5'h04);
        ev(roc_pkg::EV_DOWN, 5'h03);
        chk("out_on", 16'h0000, 16'(out_on));
        tx_q.push_back(16'h0021);
        ev(roc_pkg::EV_PG, 5'h03);
        wait_on(1'b1);
        acc(1, 8'he0, 16'h8385);
        ev(roc_pkg::EV_DOWN, 5'h06);
        ev(roc_pkg::EV_PG, 5'h05);
        chk("out_on", 16'h0001, 16'(out_on));
        tx_q.push_back(16'h0041);
        ev(roc_pkg::EV_DOWN, 5'h05);
        wait_on(1'b0);
        @(posedge mclk);
        own_enable <= 1'b0;
        $display("ordering done");
        acc(1, 8'he0, 16'h0000);
        tx_q.push_back(16'h0021);
        own_enable <= 1'b1;
        wait_on(1'b1);
        @(posedge mclk);
        fault <= 1'b1;
        in_group <= 1'b1;
        wait_on(1'b0);
        @(posedge mclk);
        fault <= 1'b0;
        retry_req <= 1'b1;
        acc(0, 8'he0, 16'h0000);
        @(negedge mclk);
        chk("grouped_retry", 16'h0000, {14'h0, retry_go, out_on});
        @(posedge mclk);
        in_group <= 1'b0;
        @(posedge mclk);
        retry_req <= 1'b0;
        for (int i = 0; i < 8 && retry_go !== 1'b1; i++)
            @(negedge mclk);
        chk("retry_go", 16'h0001, 16'(retry_go));
        @(posedge mclk);
        own_enable <= 1'b0;
        $display("fault done");
        repeat (20) @(posedge mclk);
        chk("tx_left", 16'h0000, 16'(tx_q.size()));
        complete_run();
    end
endmodule // testbench
